// File: logic/pbm_pkg.sv
// Constants for the port pin override block
package pbm_pkg;
   localparam int          PBM_PINS        = 6;
   localparam int          PBM_ADDR_W      = 3;
   localparam int          PBM_DATA_W      = 8;
   // Register offsets
   localparam logic [2:0]  PBM_OFS_OUTREG  = 3'h0;
   localparam logic [2:0]  PBM_OFS_DIR     = 3'h1;
   localparam logic [2:0]  PBM_OFS_PIN     = 3'h2;
   localparam logic [2:0]  PBM_OFS_CTRL    = 3'h3;
   localparam logic [2:0]  PBM_OFS_PADSTAT = 3'h4;
   localparam logic [2:0]  PBM_OFS_INSTAT  = 3'h5;
   // Field positions
   localparam int          PBM_CTRL_PUOFF  = 0;
   // Reset values
   localparam logic [5:0]  PBM_RST_OUTREG  = 6'h00;
   localparam logic [5:0]  PBM_RST_DIR     = 6'h00;
   localparam logic        PBM_RST_PUOFF   = 1'h0;
   localparam logic [7:0]  PBM_RD_ZERO     = 8'h00;
   localparam logic [5:0]  PBM_RST_PAD     = 6'h00;
   localparam logic        PBM_RST_FEED    = 1'h0;
   // Fuse level that means programmed
   localparam logic        PBM_FUSE_PROG   = 1'h0;
   // Pin indices
   localparam int          PBM_PIN_RST     = 5;
   localparam int          PBM_PIN_TCLK    = 2;
   localparam int          PBM_PIN_CMPB    = 1;
   localparam int          PBM_PIN_CMPA    = 0;
endpackage

// File: logic/pbm_port_override.sv
// Port pin override logic for six port pins
//
// Design decisions made here: strobed register access and the register addresses.
module pbm_port_override (
   input  wire logic       i_sys_clk,
   input  wire logic       i_reset_n,
   input  wire logic [2:0] i_addr,
   input  wire logic [7:0] i_wr_data,
   input  wire logic       i_wr_stb,
   input  wire logic       i_rd_stb,
   output logic      [7:0] o_rd_data,
   input  wire logic [5:0] i_pad_in,
   output logic      [5:0] o_pad_out,
   output logic      [5:0] o_pad_oe,
   output logic      [5:0] o_pullup_en,
   output logic      [5:0] o_inen,
   output logic      [5:0] o_analog_pad_line,
   input  wire logic       i_sleep,
   input  wire logic       i_reset_pin_disable_fuse,
   input  wire logic       i_debug_enable_fuse,
   input  wire logic       i_debug_tx,
   input  wire logic [5:0] i_pin_change_mask,
   input  wire logic       i_pin_change_en,
   input  wire logic       i_analog0_in_disable,
   input  wire logic       i_analog1_in_disable,
   input  wire logic       i_analog2_in_disable,
   input  wire logic       i_analog3_in_disable,
   input  wire logic       i_cmp_pos_in_disable,
   input  wire logic       i_cmp_neg_in_disable,
   input  wire logic       i_compare_a_out,
   input  wire logic       i_compare_a_oe,
   input  wire logic       i_compare_b_out,
   input  wire logic       i_compare_b_oe,
   output logic      [5:0] o_raw_digital_in,
   output logic            o_timer_ext_clock_in,
   output logic            o_ext_irq_zero_in
);

   logic [5:0] output_reg_r;
   logic [5:0] direction_r;
   logic       global_pullup_off_r;
   logic [5:0] pin_sync1_r;
   logic [5:0] pin_sync2_r;

   logic [5:0] pullup_ovr_en;
   logic [5:0] pullup_ovr_val;
   logic [5:0] dir_ovr_en;
   logic [5:0] dir_ovr_val;
   logic [5:0] pinval_ovr_en;
   logic [5:0] pinval_ovr_val;
   logic [5:0] toggle_ovr_en;
   logic [5:0] inen_ovr_en;
   logic [5:0] inen_ovr_val;

   logic [5:0] pullup_nxt;
   logic [5:0] pad_oe_nxt;
   logic [5:0] pad_out_nxt;
   logic [5:0] inen_nxt;
   logic [5:0] raw_nxt;
   logic [7:0] rd_nxt;

   logic       wr_outreg;
   logic       wr_dir;
   logic       wr_pin;
   logic       wr_ctrl;
   logic       reset_debug_ovr;

   // Fuse programmed reads as zero
   function automatic logic fuse_on(input logic fuse);
      fuse_on = (fuse == pbm_pkg::PBM_FUSE_PROG);
   endfunction

   // Input override enable shared by the pin-change pins
   function automatic logic pc_ovr(input logic src, input logic dis);
      pc_ovr = (src & i_pin_change_en) | dis;
   endfunction

   function automatic logic [7:0] pad6(input logic [5:0] v);
      pad6 = {2'h0, v};
   endfunction

   assign wr_outreg = i_wr_stb & (i_addr == pbm_pkg::PBM_OFS_OUTREG);
   assign wr_dir    = i_wr_stb & (i_addr == pbm_pkg::PBM_OFS_DIR);
   assign wr_pin    = i_wr_stb & (i_addr == pbm_pkg::PBM_OFS_PIN);
   assign wr_ctrl   = i_wr_stb & (i_addr == pbm_pkg::PBM_OFS_CTRL);

   assign reset_debug_ovr = fuse_on(i_reset_pin_disable_fuse)
                          & fuse_on(i_debug_enable_fuse);

   // Fixed override equations per pin
   always_comb begin
      pullup_ovr_en  = 6'h00;
      pullup_ovr_val = 6'h00;
      dir_ovr_en     = 6'h00;
      dir_ovr_val    = 6'h00;
      pinval_ovr_en  = 6'h00;
      pinval_ovr_val = 6'h00;
      toggle_ovr_en  = 6'h00;
      inen_ovr_en    = 6'h00;
      inen_ovr_val   = 6'h00;
      // Pin 5: reset and one-wire debug
      pullup_ovr_en[5]  = reset_debug_ovr;
      pullup_ovr_val[5] = 1'h1;
      dir_ovr_en[5]     = reset_debug_ovr;
      dir_ovr_val[5]    = i_debug_tx;
      inen_ovr_en[5]  = fuse_on(i_reset_pin_disable_fuse)
                      | pc_ovr(i_pin_change_mask[5],
                               i_analog0_in_disable);
      inen_ovr_val[5] = i_analog0_in_disable;
      // Pins 4 and 3: analog inputs only
      inen_ovr_en[4]  = pc_ovr(i_pin_change_mask[4],
                               i_analog2_in_disable);
      inen_ovr_val[4] = i_analog2_in_disable;
      inen_ovr_en[3]  = pc_ovr(i_pin_change_mask[3],
                               i_analog3_in_disable);
      inen_ovr_val[3] = i_analog3_in_disable;
      // Pin 2: timer clock and analog input
      inen_ovr_en[2]  = pc_ovr(i_pin_change_mask[2],
                               i_analog1_in_disable);
      inen_ovr_val[2] = i_analog1_in_disable;
      // Pin 1: compare B
      pinval_ovr_en[1]  = i_compare_b_oe;
      pinval_ovr_val[1] = i_compare_b_out;
      inen_ovr_en[1]  = pc_ovr(i_pin_change_mask[1],
                               i_cmp_neg_in_disable);
      inen_ovr_val[1] = i_cmp_neg_in_disable;
      // Pin 0: compare A
      pinval_ovr_en[0]  = i_compare_a_oe;
      pinval_ovr_val[0] = i_compare_a_out;
      inen_ovr_en[0]  = pc_ovr(i_pin_change_mask[0],
                               i_cmp_pos_in_disable);
      inen_ovr_val[0] = i_cmp_pos_in_disable;
   end

   // Pull-up: override enable wins over the register-derived choice
   always_comb begin
      for (int n = 0; n < pbm_pkg::PBM_PINS; n++) begin
         if (pullup_ovr_en[n]) begin
            pullup_nxt[n] = pullup_ovr_val[n];
         end else begin
            pullup_nxt[n] = ~direction_r[n] & output_reg_r[n]
                          & ~global_pullup_off_r;
         end
      end
   end

   // Output driver enable
   always_comb begin
      for (int n = 0; n < pbm_pkg::PBM_PINS; n++) begin
         if (dir_ovr_en[n]) begin
            pad_oe_nxt[n] = dir_ovr_val[n];
         end else begin
            pad_oe_nxt[n] = direction_r[n];
         end
      end
   end

   // Driven value; it only reaches the pad while the driver is on
   always_comb begin
      for (int n = 0; n < pbm_pkg::PBM_PINS; n++) begin
         if (pinval_ovr_en[n]) begin
            pad_out_nxt[n] = pinval_ovr_val[n];
         end else begin
            pad_out_nxt[n] = output_reg_r[n];
         end
      end
   end

   // Digital input enable; sleep only acts on pins not overridden
   always_comb begin
      for (int n = 0; n < pbm_pkg::PBM_PINS; n++) begin
         if (inen_ovr_en[n]) begin
            inen_nxt[n] = inen_ovr_val[n];
         end else begin
            inen_nxt[n] = ~i_sleep;
         end
      end
   end

   // Clamped pad level ahead of any synchroniser
   assign raw_nxt = i_pad_in & o_inen;

   // Output register bit: write, software toggle, override toggle
   // Toggle override is tied low on these pins but kept generic
   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         output_reg_r <= pbm_pkg::PBM_RST_OUTREG;
      end else if (wr_outreg) begin
         output_reg_r <= i_wr_data[5:0] ^ toggle_ovr_en;
      end else if (wr_pin) begin
         output_reg_r <= output_reg_r ^ i_wr_data[5:0] ^ toggle_ovr_en;
      end else begin
         output_reg_r <= output_reg_r ^ toggle_ovr_en;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         direction_r <= pbm_pkg::PBM_RST_DIR;
      end else if (wr_dir) begin
         direction_r <= i_wr_data[5:0];
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         global_pullup_off_r <= pbm_pkg::PBM_RST_PUOFF;
      end else if (wr_ctrl) begin
         global_pullup_off_r <= i_wr_data[pbm_pkg::PBM_CTRL_PUOFF];
      end
   end

   // Pad controls; reset leaves every pin tri-stated
   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         o_pad_oe <= pbm_pkg::PBM_RST_PAD;
      end else begin
         o_pad_oe <= pad_oe_nxt;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         o_pad_out <= pbm_pkg::PBM_RST_PAD;
      end else begin
         o_pad_out <= pad_out_nxt;
      end
   end

   // Pull-up off in reset, so an unused pin floats until configured
   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         o_pullup_en <= pbm_pkg::PBM_RST_PAD;
      end else begin
         o_pullup_en <= pullup_nxt;
      end
   end

   // Inputs clamped in reset; the peripherals see a quiet low
   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         o_inen <= pbm_pkg::PBM_RST_PAD;
      end else begin
         o_inen <= inen_nxt;
      end
   end

   // Peripheral feeds carry one flop of delay; receivers still sync
   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         o_raw_digital_in <= pbm_pkg::PBM_RST_PAD;
      end else begin
         o_raw_digital_in <= raw_nxt;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         o_timer_ext_clock_in <= pbm_pkg::PBM_RST_FEED;
      end else begin
         o_timer_ext_clock_in <= raw_nxt[pbm_pkg::PBM_PIN_TCLK];
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         o_ext_irq_zero_in <= pbm_pkg::PBM_RST_FEED;
      end else begin
         o_ext_irq_zero_in <= raw_nxt[pbm_pkg::PBM_PIN_CMPB];
      end
   end

   // Digital copy of the pad, since a two-way analog net is not allowed
   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         o_analog_pad_line <= pbm_pkg::PBM_RST_PAD;
      end else begin
         o_analog_pad_line <= i_pad_in;
      end
   end

   // Port read synchroniser on the clamped input
   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         pin_sync1_r <= pbm_pkg::PBM_RST_PAD;
      end else begin
         pin_sync1_r <= raw_nxt;
      end
   end

   // Only the second stage is read, never the possibly metastable first
   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         pin_sync2_r <= pbm_pkg::PBM_RST_PAD;
      end else begin
         pin_sync2_r <= pin_sync1_r;
      end
   end

   always_comb begin
      rd_nxt = pbm_pkg::PBM_RD_ZERO;
      case (i_addr)
         pbm_pkg::PBM_OFS_OUTREG:  rd_nxt = pad6(output_reg_r);
         pbm_pkg::PBM_OFS_DIR:     rd_nxt = pad6(direction_r);
         pbm_pkg::PBM_OFS_PIN:     rd_nxt = pad6(pin_sync2_r);
         pbm_pkg::PBM_OFS_CTRL:    rd_nxt = {7'h00, global_pullup_off_r};
         pbm_pkg::PBM_OFS_PADSTAT: rd_nxt = pad6(o_pad_oe);
         pbm_pkg::PBM_OFS_INSTAT:  rd_nxt = pad6(o_inen);
         default:                  rd_nxt = pbm_pkg::PBM_RD_ZERO;
      endcase
   end

   // Read data valid only in the cycle after the strobe
   // Zero otherwise, so a stale read never looks fresh
   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         o_rd_data <= pbm_pkg::PBM_RD_ZERO;
      end else if (i_rd_stb) begin
         o_rd_data <= rd_nxt;
      end else begin
         o_rd_data <= pbm_pkg::PBM_RD_ZERO;
      end
   end

endmodule

// File: test/pbm_port_override_sva.sv
// Port-level assertions for the port pin override block
module pbm_port_override_sva (
   input wire logic       i_sys_clk,
   input wire logic       i_reset_n,
   input wire logic       i_sleep,
   input wire logic       i_reset_pin_disable_fuse,
   input wire logic       i_debug_enable_fuse,
   input wire logic       i_debug_tx,
   input wire logic [5:0] i_pin_change_mask,
   input wire logic       i_pin_change_en,
   input wire logic       i_analog0_in_disable,
   input wire logic       i_cmp_neg_in_disable,
   input wire logic       i_compare_b_out,
   input wire logic       i_compare_b_oe,
   input wire logic [5:0] i_pad_in,
   input wire logic [5:0] o_pad_out,
   input wire logic [5:0] o_pad_oe,
   input wire logic [5:0] o_pullup_en,
   input wire logic [5:0] o_inen,
   input wire logic [5:0] o_raw_digital_in,
   input wire logic       o_timer_ext_clock_in,
   input wire logic       o_ext_irq_zero_in
);
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_reset_n);
   AST_DBG_OVR: assert property (
      !i_reset_pin_disable_fuse && !i_debug_enable_fuse
      |=> o_pullup_en[5] && o_pad_oe[5] == $past(i_debug_tx))
      else $error("pin 5 debug override");
   AST_CMP_B: assert property (
      i_compare_b_oe |=> !o_pad_oe[1]
      || o_pad_out[1] == $past(i_compare_b_out))
      else $error("pin 1 value override");
   AST_INEN_OVR: assert property (
      i_pin_change_mask[1] && i_pin_change_en || i_cmp_neg_in_disable
      |=> o_inen[1] == $past(i_cmp_neg_in_disable))
      else $error("pin 1 input enable override");
   AST_SLEEP: assert property (
      !(i_pin_change_mask[1] && i_pin_change_en || i_cmp_neg_in_disable)
      |=> o_inen[1] == !$past(i_sleep))
      else $error("pin 1 sleep clamp");
   AST_RST_INEN: assert property (
      !i_reset_pin_disable_fuse |=> o_inen[5] == $past(i_analog0_in_disable))
      else $error("pin 5 input enable override");
   AST_RAW: assert property (
      1'h1 |=> o_raw_digital_in == ($past(i_pad_in) & $past(o_inen)))
      else $error("raw input");
   AST_FEEDS: assert property (
      o_timer_ext_clock_in == o_raw_digital_in[2]
      && o_ext_irq_zero_in == o_raw_digital_in[1])
      else $error("peripheral feed");
   AST_PU_DIR: assert property (
      (o_pullup_en[4:0] & o_pad_oe[4:0]) == 5'h00)
      else $error("pull-up on a driven pin");
   cover property (o_pullup_en[5] && o_pad_oe[5]);
   cover property (i_compare_b_oe ##1 o_pad_oe[1]);
   cover property (i_sleep ##1 o_inen == 6'h00);
endmodule
bind pbm_port_override pbm_port_override_sva pbm_port_override_sva_i (.*);

// File: test/pbm_periph_model.sv
// Peripheral-side model that sources the pin overrides
module pbm_periph_model (
   input  wire logic       i_sys_clk,
   input  wire logic [5:0] i_dis,
   input  wire logic [4:0] i_ctl,
   input  wire logic       i_irq,
   output logic      [5:0] o_dis = 6'h00,
   output logic      [4:0] o_ctl = 5'h00,
   output logic            o_irq_sync = 1'h0
);
   logic irq_meta_r = 1'h0;
   // Owners launch their own override sources just after the edge
   always @(posedge i_sys_clk) begin
      o_dis <= i_dis;
      o_ctl <= i_ctl;
   end
   // Raw input is unsynchronised, so the receiver adds two flops
   always @(posedge i_sys_clk) begin
      irq_meta_r <= i_irq;
      o_irq_sync <= irq_meta_r;
   end
endmodule

// File: test/pbm_port_override_tb.sv
// Self-checking bench for the port pin override block
module pbm_port_override_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic       i_sys_clk = 1'h0, i_reset_n = 1'h0, tgl = 1'h0;
   logic       i_wr_stb = 1'h0, i_rd_stb = 1'h0, ext_en = 1'h0;
   logic       i_sleep = 1'h0, i_pin_change_en = 1'h0;
   logic       i_reset_pin_disable_fuse = 1'h1, i_debug_enable_fuse = 1'h1;
   logic       o_timer_ext_clock_in, o_ext_irq_zero_in;
   logic [2:0] i_addr = 3'h0;
   logic [4:0] ctl_r = 5'h00;
   logic [5:0] i_pin_change_mask = 6'h00, dis_r = 6'h00, ext_v = 6'h00;
   logic [5:0] o_pad_out, o_pad_oe, o_pullup_en, o_raw_digital_in, o_inen;
   logic [5:0] o_analog_pad_line;
   logic [7:0] i_wr_data = 8'h00, o_rd_data, e;
   wire        i_debug_tx, i_compare_a_out, i_compare_a_oe, irq_sync;
   wire        i_compare_b_out, i_compare_b_oe, i_cmp_pos_in_disable;
   wire        i_cmp_neg_in_disable, i_analog0_in_disable;
   wire        i_analog1_in_disable, i_analog2_in_disable;
   wire        i_analog3_in_disable;
   wire  [5:0] i_pad_in;
   int         miscompares = 0, tests_run = 0;
   // Our driver wins; else bench drive, pull-up, or a toggling float
   assign i_pad_in = o_pad_oe & o_pad_out
      | ~o_pad_oe & (ext_en ? ext_v : o_pullup_en | {6{tgl}});
   always #12.5 i_sys_clk = ~i_sys_clk;
   always @(posedge i_sys_clk) tgl <= ~tgl;
   pbm_port_override pbm_port_override_i (.*);
   pbm_periph_model pbm_periph_model_i (.i_sys_clk(i_sys_clk),
      .i_dis(dis_r), .i_ctl(ctl_r), .i_irq(o_ext_irq_zero_in),
      .o_dis({i_analog0_in_disable, i_analog2_in_disable,
         i_analog3_in_disable, i_analog1_in_disable,
         i_cmp_neg_in_disable, i_cmp_pos_in_disable}),
      .o_ctl({i_debug_tx, i_compare_b_oe, i_compare_b_out,
         i_compare_a_oe, i_compare_a_out}),
      .o_irq_sync(irq_sync));
   task automatic chk(input logic [7:0] g, input logic [7:0] w);
      tests_run++;
      if (g !== w) begin
         miscompares++;
         $display("unexpected at %0t: got %h want %h", $time, g, w);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge i_sys_clk);
      i_addr <= a;
      i_wr_data <= d;
      i_wr_stb <= 1'h1;
      @(posedge i_sys_clk);
      i_wr_stb <= 1'h0;
   endtask
   task automatic rdc(input logic [2:0] a, input logic [7:0] w);
      @(posedge i_sys_clk);
      i_addr <= a;
      i_rd_stb <= 1'h1;
      @(posedge i_sys_clk);
      i_rd_stb <= 1'h0;
      // Data stand until the next edge; read there before they move
      @(posedge i_sys_clk);
      chk(o_rd_data, w);
   endtask
   // Slowest path, inen to synchronised irq, lags four edges; wait five
   task automatic st;
      repeat (5) @(posedge i_sys_clk);
   endtask
   task automatic conclude;
      if (miscompares == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge i_sys_clk);
      i_reset_n <= 1'h1;
      rdc(pbm_pkg::PBM_OFS_CTRL, 8'h00);
      rdc(3'h6, 8'h00);
      wr(pbm_pkg::PBM_OFS_OUTREG, 8'h3F);
      wr(pbm_pkg::PBM_OFS_DIR, 8'h0F);
      st;
      chk({2'h0, o_pullup_en}, 8'h30);
      chk({2'h0, o_pad_oe}, 8'h0F);
      for (int k = 0; k < 16; k++) begin
         ctl_r <= 5'(k);
         st;
         e = {6'h03, k[3] ? k[2] : 1'h1, k[1] ? k[0] : 1'h1};
         chk({2'h0, o_pad_out & o_pad_oe}, e);
      end
      wr(pbm_pkg::PBM_OFS_CTRL, 8'h01);
      st;
      chk({2'h0, o_pullup_en}, 8'h00);
      i_reset_pin_disable_fuse <= 1'h0;
      i_debug_enable_fuse <= 1'h0;
      for (int k = 0; k < 2; k++) begin
         ctl_r <= {k[0], 4'h0};
         st;
         chk({2'h0, o_pullup_en}, 8'h20);
         chk({2'h0, o_pad_oe}, {2'h0, k[0], 5'h0F});
      end
      i_debug_enable_fuse <= 1'h1;
      st;
      chk({2'h0, o_pad_oe}, 8'h0F);
      chk({2'h0, o_inen}, 8'h1F);
      i_reset_pin_disable_fuse <= 1'h1;
      wr(pbm_pkg::PBM_OFS_DIR, 8'h00);
      i_sleep <= 1'h1;
      for (int k = 0; k < 7; k++) begin
         dis_r <= 6'(1 << k);
         st;
         chk({2'h0, o_inen}, 8'(1 << k) & 8'h3F);
      end
      i_sleep <= 1'h0;
      dis_r <= 6'h00;
      i_pin_change_mask <= 6'h3F;
      i_pin_change_en <= 1'h1;
      st;
      chk({2'h0, o_inen}, 8'h00);
      i_pin_change_en <= 1'h0;
      ext_en <= 1'h1;
      for (int k = 0; k < 2; k++) begin
         ext_v <= k[0] ? 6'h15 : 6'h2A;
         st;
         e = {2'h0, ext_v};
         chk({2'h0, o_inen}, 8'h3F);
         chk({2'h0, o_raw_digital_in}, e);
         chk({2'h0, o_analog_pad_line}, e);
         chk({6'h00, o_timer_ext_clock_in, irq_sync},
             (e >> 1) & 8'h03);
         rdc(pbm_pkg::PBM_OFS_PIN, e);
      end
      i_sleep <= 1'h1;
      st;
      chk({2'h0, o_raw_digital_in}, 8'h00);
      conclude;
   end
endmodule
